// >>> rtl/clc_regs.svh
/*
 * Command codes, field positions, reset values and timing figures of the
 * per-channel line control registers.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef CLC_REGS_SVH
`define CLC_REGS_SVH

// ==========================================================
// Command byte layout
`define CLC_CMD_WRITE_BIT   7
`define CLC_CMD_ADDR_MSB    6
`define CLC_ADDR_DEBOUNCE   7'h02
`define CLC_ADDR_PWR_GAIN   7'h08
`define CLC_ADDR_TONE       7'h09

// ==========================================================
// Field positions
`define CLC_DB_B_MSB        7
`define CLC_DB_B_LSB        4
`define CLC_DB_A_MSB        3
`define CLC_DB_A_LSB        0
`define CLC_PWR_DOWN_BIT    7
`define CLC_RX_CUT_BIT      6
`define CLC_ADC_GAIN_BIT    5
`define CLC_DAC_GAIN_BIT    4
`define CLC_TONE_B_BIT      1
`define CLC_TONE_A_BIT      0

// ==========================================================
// Reset values
`define CLC_DEBOUNCE_RST    8'h00
`define CLC_PWR_GAIN_RST    4'h8
`define CLC_TONE_RST        4'h0

// ==========================================================
// Timing: one debounce code step, clock in kHz
`define CLC_STEP_MS         2
`define CLC_CLK_KHZ         200000
`define CLC_STEP_CYCLES     (`CLC_STEP_MS * `CLC_CLK_KHZ)

`endif

// >>> rtl/clc_pkg.sv
/*
 * Types shared by the per-channel line control register block.
 * Assumes nothing of its surroundings.
 */
package clc_pkg;
	localparam int NUM_CHAN = 4;
	localparam int CNT_W    = 23;

	// ==========================================================
	// One command from the serial control channel
	typedef struct packed {
		logic       valid;
		logic [1:0] chan;
		logic [7:0] code;
		logic [7:0] data;
	} clc_cmd_t;

	// ==========================================================
	// Per-channel control outputs, laid out as the power and tone bytes
	typedef struct packed {
		logic       pwrDown;
		logic       rxCutoff;
		logic       adcGainStep;
		logic       dacGainStep;
		logic [1:0] toneSpare;
		logic       toneBEnable;
		logic       toneAEnable;
	} clc_chan_t;

	// ==========================================================
	// Read answer
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} clc_rsp_t;
endpackage : clc_pkg

// >>> rtl/clc_line_control.sv
/*
 * Per-channel local control registers of a four-channel codec: line input
 * debounce, power down, receive cutoff, converter gain steps, tone enables.
 * Assumes commands arrive already deframed from the serial control channel,
 * one per cycle at most, on sys_clk; line inputs are asynchronous pins.
 */
// Overview of operation
// - The first line input of each channel is debounced for 2 ms per step of its 4-bit code, zero meaning none.
// - The second line input of each channel is debounced likewise by its own 4-bit code, reset zero.
// - Debounce register is command 02H read / 82H write, second input code in bits 7:4, first in 3:0.
// - Power/cutoff/gain register is 08H read / 88H write; command bit 7 means write, low bits the address.
// - Data bit 7 powers the channel down when set, and it resets set.
// - Data bit 6 cuts off the receive path when set, reset clear.
// - Data bit 5 selects +6 dB converter input gain when set, 0 dB when clear by default.
// - Data bit 4 selects -6 dB converter output gain when set, 0 dB when clear by default.
// - Tone register is 09H read / 89H write, bit 1 enables tone B and bit 0 tone A, both reset off.
// - Each of the four channels holds its own copy of these registers, chosen by the command's channel.
`timescale 1ns/1ps
`include "clc_regs.svh"

module clc_line_control #(
	parameter int unsigned STEP_CYCLES = `CLC_STEP_CYCLES
) (
	input  wire logic                                  sys_clk,
	input  wire logic                                  resetn,
	input  wire clc_pkg::clc_cmd_t                     cmd,
	input  wire logic [clc_pkg::NUM_CHAN-1:0]          lineSignalInA,
	input  wire logic [clc_pkg::NUM_CHAN-1:0]          lineSignalInB,
	output clc_pkg::clc_rsp_t                          rsp,
	output clc_pkg::clc_chan_t [clc_pkg::NUM_CHAN-1:0] chanCtrl,
	output logic [clc_pkg::NUM_CHAN-1:0]               lineLevelA,
	output logic [clc_pkg::NUM_CHAN-1:0]               lineLevelB
);
	import clc_pkg::*;

	// Debounce limit in cycles for a code; 30 ms fits in CNT_W bits
	function automatic logic [CNT_W-1:0] stepLimit(input logic [3:0] code);
		stepLimit = CNT_W'(32'(code) * STEP_CYCLES);
	endfunction : stepLimit

	// ==========================================================
	// Reset release
	logic rstMeta;
	logic rstSync;
	logic rstn;

	// Two stages so the release never lands near a clock edge
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end
	assign rstn = rstSync;

	// ==========================================================
	// Command decode
	wire       isWrite  = cmd.code[`CLC_CMD_WRITE_BIT];
	wire [6:0] regAddr  = cmd.code[`CLC_CMD_ADDR_MSB:0];
	wire       hitDb    = regAddr == `CLC_ADDR_DEBOUNCE;
	wire       hitPwr   = regAddr == `CLC_ADDR_PWR_GAIN;
	wire       hitTone  = regAddr == `CLC_ADDR_TONE;
	wire       wrDb     = cmd.valid && isWrite && hitDb;
	wire       wrPwr    = cmd.valid && isWrite && hitPwr;
	wire       wrTone   = cmd.valid && isWrite && hitTone;
	wire       rdAny    = cmd.valid && !isWrite;

	// ==========================================================
	// Register storage, one copy per channel
	logic [7:0] dbReg [NUM_CHAN];

	// Writes touch only the addressed channel
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				dbReg[c]       <= `CLC_DEBOUNCE_RST;
				chanCtrl[c]    <= {`CLC_PWR_GAIN_RST, `CLC_TONE_RST};
			end
		end else begin
			if (wrDb)
				dbReg[cmd.chan] <= cmd.data;
			// Low nibble is expected zero and is not kept
			if (wrPwr)
				chanCtrl[cmd.chan][7:4] <= cmd.data[7:4];
			if (wrTone)
				chanCtrl[cmd.chan][3:0] <= cmd.data[3:0];
		end
	end

	// ==========================================================
	// Read path: answer one cycle after the command
	wire [7:0] pwrRead  = {chanCtrl[cmd.chan][7:4], 4'h0};
	wire [7:0] toneRead = {4'h0, chanCtrl[cmd.chan][3:0]};
	wire [7:0] rdSel    = hitDb  ? dbReg[cmd.chan] :
	                      hitPwr ? pwrRead :
	                      hitTone ? toneRead : 8'h00;

	// Unmapped reads still answer, with zero, so the host never waits
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			rsp <= '0;
		else begin
			rsp.valid <= rdAny;
			rsp.data  <= rdAny ? rdSel : 8'h00;
		end
	end

	// ==========================================================
	// Line input synchronisers and debounce, A inputs first then B
	logic [2*NUM_CHAN-1:0] pinIn;
	logic [2*NUM_CHAN-1:0] syncMeta;
	logic [2*NUM_CHAN-1:0] syncMid;
	logic [2*NUM_CHAN-1:0] syncLate;
	logic [2*NUM_CHAN-1:0] stableIn;
	logic [2*NUM_CHAN-1:0] dbOut;
	logic [CNT_W-1:0]      holdCnt [2*NUM_CHAN];
	logic [3:0]            dbCode  [2*NUM_CHAN];

	assign pinIn = {lineSignalInB, lineSignalInA};

	// Three stages; a change counts only once the last two agree
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			syncMeta <= '0;
			syncMid  <= '0;
			syncLate <= '0;
			stableIn <= '0;
		end else begin
			syncMeta <= pinIn;
			syncMid  <= syncMeta;
			syncLate <= syncMid;
			stableIn <= (syncMid & syncLate) | (stableIn & (syncMid ^ syncLate));
		end
	end

	for (genvar i = 0; i < 2*NUM_CHAN; i++) begin : g_db
		wire             isB     = i >= NUM_CHAN;
		wire [CNT_W-1:0] limit   = stepLimit(dbCode[i]);
		wire             differs = stableIn[i] != dbOut[i];
		wire             expired = (holdCnt[i] + CNT_W'(1)) >= limit;

		assign dbCode[i] = isB ? dbReg[i % NUM_CHAN][`CLC_DB_B_MSB:`CLC_DB_B_LSB]
		                       : dbReg[i % NUM_CHAN][`CLC_DB_A_MSB:`CLC_DB_A_LSB];

		// Counter restarts whenever the input returns to the held level
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				holdCnt[i] <= '0;
				dbOut[i]   <= 1'b0;
			end else if (!differs) begin
				holdCnt[i] <= '0;
			end else if (dbCode[i] == 4'h0 || expired) begin
				holdCnt[i] <= '0;
				dbOut[i]   <= stableIn[i];
			end else begin
				holdCnt[i] <= holdCnt[i] + CNT_W'(1);
			end
		end
	end

	assign lineLevelA = dbOut[NUM_CHAN-1:0];
	assign lineLevelB = dbOut[2*NUM_CHAN-1:NUM_CHAN];

	// ==========================================================
	// Checks
	logic [1:0] lastChan;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			lastChan <= 2'b00;
		else
			lastChan <= cmd.chan;
	end

	dbwrite_lands_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		wrDb |=> dbReg[lastChan] == $past(cmd.data)) else $error("debounce write lost");

	pwrdown_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		wrPwr |=> chanCtrl[lastChan].pwrDown == $past(cmd.data[7])) else $error("power down wrong");

	rxcut_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		wrPwr |=> chanCtrl[lastChan].rxCutoff == $past(cmd.data[6])) else $error("cutoff wrong");

	gain_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		wrPwr |=> {chanCtrl[lastChan].adcGainStep, chanCtrl[lastChan].dacGainStep} == $past(cmd.data[5:4]))
		else $error("gain steps wrong");

	tone_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		wrTone |=> {chanCtrl[lastChan].toneBEnable, chanCtrl[lastChan].toneAEnable} == $past(cmd.data[1:0]))
		else $error("tone enables wrong");

	read_answer_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		rdAny |=> rsp.valid && rsp.data == $past(rdSel)) else $error("read answer wrong");

	other_chan_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		wrPwr && cmd.chan != 2'd0 |=> $stable(chanCtrl[0])) else $error("wrong channel written");

	db_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$changed(dbOut[0]) |-> $past(dbCode[0]) == 4'h0 || $past(holdCnt[0]) + CNT_W'(1) >= $past(g_db[0].limit))
		else $error("early debounce change");

	// ==========================================================
	// Read answer checks
	// The answer is a one-cycle pulse; data must be quiet around it so
	// a host that ignores valid still never picks up a stale byte.

	rsp_idle_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!rsp.valid |-> rsp.data == 8'h00)
		else $error("answer data not quiet");

	rsp_pulse_only_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		rsp.valid |-> $past(rdAny))
		else $error("answer without read");

	rsp_no_extra_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!rdAny |=> !rsp.valid)
		else $error("answer pulse too long");

	pwr_low_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		rdAny && hitPwr |=> rsp.data[3:0] == 4'h0)
		else $error("power read low nibble set");

	tone_high_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		rdAny && hitTone |=> rsp.data[7:4] == 4'h0)
		else $error("tone read high nibble set");

	unmapped_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		rdAny && !hitDb && !hitPwr && !hitTone |=> rsp.data == 8'h00)
		else $error("unmapped read not zero");

	db_read_back_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		rdAny && hitDb |=> rsp.data == $past(dbReg[cmd.chan]))
		else $error("debounce read wrong");

	pwr_read_back_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		rdAny && hitPwr |=> rsp.data[7:4] == $past(chanCtrl[cmd.chan][7:4]))
		else $error("power read wrong");

	// ==========================================================
	// Write isolation checks
	// Reads and unmapped writes must leave every control bit alone, and
	// a write to one channel must never leak into another.

	unmapped_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		cmd.valid && isWrite && !hitDb && !hitPwr && !hitTone |=> $stable(chanCtrl))
		else $error("unmapped write landed");

	read_no_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		rdAny |=> $stable(chanCtrl))
		else $error("read changed controls");

	db_other_chan_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		wrDb && cmd.chan != 2'd0 |=> $stable(dbReg[0]))
		else $error("debounce leaked");

	tone_other_chan_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		wrTone && cmd.chan != 2'd1 |=> $stable(chanCtrl[1]))
		else $error("tone write leaked");

	pwr_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!(wrPwr && cmd.chan == 2'd0) |=> $stable(chanCtrl[0][7:4]))
		else $error("power bits moved");

	tone_spare_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		wrTone |=> chanCtrl[lastChan].toneSpare == $past(cmd.data[3:2]))
		else $error("tone spare bits wrong");

	// ==========================================================
	// Synchroniser and debounce checks
	// Channel 0 and the last channel stand in for the rest; all copies
	// come from the same generate body, so a fault shows on any of them.

	sync_agree_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$changed(stableIn[0]) |-> $past(syncMid[0]) == $past(syncLate[0]))
		else $error("input accepted before agreement");

	syncb_agree_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$changed(stableIn[NUM_CHAN]) |-> $past(syncMid[NUM_CHAN]) == $past(syncLate[NUM_CHAN]))
		else $error("second input accepted early");

	db_follows_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$changed(dbOut[0]) |-> dbOut[0] == $past(stableIn[0]))
		else $error("debounced level wrong");

	db_zero_pass_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		dbCode[0] == 4'h0 && g_db[0].differs |=> dbOut[0] == $past(stableIn[0]))
		else $error("code zero did not pass");

	dbb_zero_pass_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		dbCode[NUM_CHAN] == 4'h0 && g_db[NUM_CHAN].differs |=> dbOut[NUM_CHAN] == $past(stableIn[NUM_CHAN]))
		else $error("second input code zero did not pass");

	dbb_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$changed(dbOut[NUM_CHAN]) |-> $past(dbCode[NUM_CHAN]) == 4'h0 ||
			$past(holdCnt[NUM_CHAN]) + CNT_W'(1) >= $past(g_db[NUM_CHAN].limit))
		else $error("early second input change");

	db_last_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$changed(dbOut[NUM_CHAN-1]) |-> $past(dbCode[NUM_CHAN-1]) == 4'h0 ||
			$past(holdCnt[NUM_CHAN-1]) + CNT_W'(1) >= $past(g_db[NUM_CHAN-1].limit))
		else $error("early last channel change");

	// Held levels only move through the debounce path, never on their own
	db_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!g_db[0].differs |=> $stable(dbOut[0]))
		else $error("level moved without cause");
endmodule : clc_line_control

// >>> sim/clc_host_model.sv
/*
 * Host controller model for the line control registers: sends command and
 * data byte pairs and collects read answers.
 * Assumes the block takes a command at the edge where cmd.valid is high and
 * answers a read within a few cycles.
 */
`timescale 1ns/1ps

module clc_host_model (
	input  wire logic             sys_clk,
	input  wire clc_pkg::clc_rsp_t rsp,
	output clc_pkg::clc_cmd_t      cmd
);
	import clc_pkg::*;

	initial cmd = '0;

	// ==========================================================
	// Command issue: one byte pair per call, then the bus shows junk
	task automatic wr(input logic [1:0] ch, input logic [7:0] code, input logic [7:0] data);
		logic [7:0] d;
		d = data;
		if (code == 8'h88) d[3:0] = 4'h0;
		if (code == 8'h89) d[3:2] = 2'b11;
		@(posedge sys_clk);
		cmd <= '{valid: 1'b1, chan: ch, code: code, data: d};
		@(posedge sys_clk);
		// Released fields inverted so nothing can lean on stale values
		cmd <= '{valid: 1'b0, chan: ~ch, code: ~code, data: ~d};
	endtask : wr

	// Read: bounded wait for the answer pulse
	task automatic rd(input logic [1:0] ch, input logic [7:0] code, output logic [7:0] data);
		wr(ch, code, 8'h00);
		data = 8'hxx;
		// Look between edges, where the registered answer has settled
		for (int i = 0; i < 4; i++) begin
			@(negedge sys_clk);
			if (rsp.valid === 1'b1) begin
				data = rsp.data;
				break;
			end
		end
	endtask : rd
endmodule : clc_host_model

// >>> sim/clc_line_control_tb_top.sv
/*
 * Self-checking bench for the line control registers: reset values, per
 * channel storage, unmapped access and line input debounce.
 * Assumes the host model drives the command port; debounce step shortened.
 */
`timescale 1ns/1ps

module clc_line_control_tb_top;
	import clc_pkg::*;
	localparam int unsigned STEP = 4;
	logic                     sys_clk       = 1'b0;
	logic                     resetn        = 1'b0;
	logic [NUM_CHAN-1:0]      lineSignalInA = '0;
	logic [NUM_CHAN-1:0]      lineSignalInB = '0;
	logic [NUM_CHAN-1:0]      lineLevelA;
	logic [NUM_CHAN-1:0]      lineLevelB;
	clc_cmd_t                 cmd;
	clc_rsp_t                 rsp;
	clc_chan_t [NUM_CHAN-1:0] chanCtrl;
	logic [7:0]               got;
	int                       mismatches = 0;
	int                       nChecks    = 0;
	int                       cycles     = 0;

	clc_host_model host (.sys_clk(sys_clk), .rsp(rsp), .cmd(cmd));
	clc_line_control #(.STEP_CYCLES(STEP)) DUT (
		.sys_clk(sys_clk), .resetn(resetn), .cmd(cmd), .lineSignalInA(lineSignalInA),
		.lineSignalInB(lineSignalInB), .rsp(rsp), .chanCtrl(chanCtrl),
		.lineLevelA(lineLevelA), .lineLevelB(lineLevelB));

	// ==========================================================
	// Clock, hang guard and reporting
	always #2.5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			finishTest();
		end
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		nChecks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic finishTest();
		if (mismatches == 0 && nChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finishTest

	// ==========================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		// Reset values, every channel
		for (int c = 0; c < NUM_CHAN; c++) begin
			chk(chanCtrl[c], 8'h80);
			host.rd(2'(c), 8'h02, got);
			chk(got, 8'h00);
			host.rd(2'(c), 8'h08, got);
			chk(got, 8'h80);
			host.rd(2'(c), 8'h09, got);
			chk(got, 8'h00);
		end
		// Distinct values per channel; one control bit and tone code each
		for (int c = 0; c < NUM_CHAN; c++) begin
			host.wr(2'(c), 8'h82, {4'(c), 4'(15 - c)});
			host.wr(2'(c), 8'h88, 8'h10 << c);
			host.wr(2'(c), 8'h89, 8'(c));
		end
		for (int c = 0; c < NUM_CHAN; c++) begin
			host.rd(2'(c), 8'h02, got);
			chk(got, {4'(c), 4'(15 - c)});
			host.rd(2'(c), 8'h08, got);
			chk(got, 8'h10 << c);
			host.rd(2'(c), 8'h09, got);
			chk(got, 8'h0C | 8'(c));
			chk(chanCtrl[c], (8'h10 << c) | 8'h0C | 8'(c));
		end
		// Unmapped address: write dropped, read answers zero
		host.wr(2'd0, 8'h85, 8'hFF);
		host.rd(2'd0, 8'h05, got);
		chk(got, 8'h00);
		chk(chanCtrl[0], 8'h1C);
		// Debounce on channel 0: first input 3 steps, second input none
		host.wr(2'd0, 8'h82, 8'h03);
		lineSignalInB[0] <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk(8'(lineLevelB), 8'h01);
		lineSignalInA[0] <= 1'b1;
		repeat (6) @(posedge sys_clk);
		lineSignalInA[0] <= 1'b0;
		repeat (20) @(posedge sys_clk);
		chk(8'(lineLevelA), 8'h00);
		lineSignalInA[0] <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk(8'(lineLevelA), 8'h00);
		repeat (20) @(posedge sys_clk);
		chk(8'(lineLevelA), 8'h01);
		finishTest();
	end
endmodule : clc_line_control_tb_top
